/* core/acr_clock_divider.sv */
// divider making a one-cycle enable from the system clock
`timescale 1ns/10ps
module acr_clock_divider (
  input wire logic sys_clk, // system clock
  input wire logic resetn, // synchronous reset, active low
  input wire logic [2:0] ratio, // divide by ratio plus one
  output logic clk_en // one-cycle enable at divided rate
);
  import acr_pkg::*;
  logic [2:0] count;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      count <= 3'h0;
      clk_en <= 1'b0;
    end else if (count >= ratio) begin
      count <= 3'h0;
      clk_en <= 1'b1;
    end else begin
      count <= count + 3'h1;
      clk_en <= 1'b0;
    end
  end
endmodule : acr_clock_divider

/* core/acr_config_regs.sv */
// serial-port configuration registers of a dual-channel converter
`timescale 1ns/10ps
module acr_config_regs (
  input wire logic sys_clk, // system clock, 25 MHz
  input wire logic resetn, // synchronous reset, active low
  input wire logic port_select_n, // serial frame select, active low
  input wire logic serial_clk, // serial clock, sampled as data
  input wire logic sdio_in, // shared data pin input
  output logic sdio_out, // shared data pin output
  output logic sdio_oe, // shared data pin drive enable
  output acr_pkg::acr_power_t power_mode, // global power mode
  output logic stabiliser_on, // duty-cycle stabiliser enable
  output logic div_enable, // divided sample clock enable
  output logic override_go, // transfer override pulse
  output logic [acr_pkg::NUM_COPIES-1:0] local_sel // index bits for copies
);
  import acr_pkg::*;
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0] port_cfg;
  logic [7:0] ch_index;
  logic [7:0] power_reg;
  logic [7:0] clk_stab;
  logic [7:0] clk_div;
  logic [7:0] xfer;
  // one local register per copy: bits 0..3 = A, B, frame, data clock
  logic [7:0] local_scratch [NUM_COPIES];
  logic [3:0] copy_sel;
  logic soft_reset;
  logic clk_div_en;

  // ---------------------------------------------------------------
  // serial frame engine
  // ---------------------------------------------------------------
  acr_phase_t phase;
  logic sclk_q;
  logic [4:0] bit_cnt;
  logic [15:0] instr;
  logic [7:0] shift_in;
  logic [7:0] shift_out;
  logic [15:0] cur_addr;
  logic rise;
  logic fall;
  logic wr_strobe;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic lsb_first;
  logic [7:0] in_byte;
  logic [7:0] in_byte_rev;

  assign rise = serial_clk & ~sclk_q;
  assign fall = ~serial_clk & sclk_q;
  assign lsb_first = port_cfg[LSB_FIRST_BIT];
  assign in_byte = {shift_in[6:0], sdio_in};
  assign in_byte_rev = {<<{in_byte}};
  assign copy_sel = {ch_index[5], ch_index[4], ch_index[1], ch_index[0]};

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= serial_clk;
    end
  end

  // 16-bit instruction then 8-bit words, address autoincrements
  always_ff @(posedge sys_clk) begin
    if (!resetn || port_select_n) begin
      phase <= ACR_INSTR;
      bit_cnt <= 5'h00;
      instr <= 16'h0000;
      shift_in <= 8'h00;
      cur_addr <= 16'h0000;
      wr_strobe <= 1'b0;
      wr_data <= 8'h00;
    end else begin
      wr_strobe <= 1'b0;
      if (rise) begin
        case (phase)
          ACR_INSTR: begin
            instr <= {instr[14:0], sdio_in};
            if (bit_cnt == 5'(INSTR_BITS - 1)) begin
              bit_cnt <= 5'h00;
              cur_addr <= {3'h0, instr[11:0], sdio_in};
              phase <= instr[14] ? ACR_RDATA : ACR_WDATA;
            end else begin
              bit_cnt <= bit_cnt + 5'h01;
            end
          end
          ACR_WDATA: begin
            shift_in <= in_byte;
            if (bit_cnt == 5'(WORD_BITS - 1)) begin
              bit_cnt <= 5'h00;
              wr_strobe <= 1'b1;
              wr_data <= lsb_first ? in_byte_rev : in_byte;
            end else begin
              bit_cnt <= bit_cnt + 5'h01;
            end
          end
          ACR_RDATA: begin
            if (bit_cnt == 5'(WORD_BITS - 1)) begin
              bit_cnt <= 5'h00;
              cur_addr <= cur_addr + 16'h0001;
            end else begin
              bit_cnt <= bit_cnt + 5'h01;
            end
          end
          default: phase <= ACR_INSTR;
        endcase
      end else if (wr_strobe) begin
        cur_addr <= cur_addr + 16'h0001;
      end
    end
  end

  // read data path; multi-select reads give the lowest selected copy, channel A first
  always_comb begin
    case (cur_addr)
      ADDR_PORT_CFG: rd_data = port_cfg;
      ADDR_PART_ID: rd_data = PART_ID_VALUE;
      ADDR_SPEED: rd_data = SPEED_GRADE_VALUE;
      ADDR_CH_INDEX: rd_data = ch_index;
      ADDR_POWER: rd_data = power_reg;
      ADDR_CLK_STAB: rd_data = clk_stab;
      ADDR_CLK_DIV: rd_data = clk_div;
      ADDR_XFER: rd_data = xfer;
      ADDR_LOCAL: rd_data = ch_index[CH_A_BIT] ? local_scratch[0]
                : ch_index[CH_B_BIT] ? local_scratch[1]
                : ch_index[4] ? local_scratch[2] : local_scratch[3];
      default: rd_data = 8'h00;
    endcase
  end

  // output shifter drives the shared pin only during read words
  always_ff @(posedge sys_clk) begin
    if (!resetn || port_select_n) begin
      shift_out <= 8'h00;
      sdio_out <= 1'b0;
      sdio_oe <= 1'b0;
    end else if (phase == ACR_RDATA) begin
      sdio_oe <= 1'b1;
      if (fall) begin
        if (bit_cnt == 5'h00) begin
          sdio_out <= lsb_first ? rd_data[0] : rd_data[7];
          shift_out <= lsb_first ? {1'b0, rd_data[7:1]}
                                 : {rd_data[6:0], 1'b0};
        end else begin
          sdio_out <= lsb_first ? shift_out[0] : shift_out[7];
          shift_out <= lsb_first ? {1'b0, shift_out[7:1]}
                                 : {shift_out[6:0], 1'b0};
        end
      end
    end else begin
      sdio_oe <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  assign soft_reset = port_cfg[SOFT_RESET_BIT];

  // soft reset lasts one cycle, then the bit clears itself
  always_ff @(posedge sys_clk) begin
    if (!resetn || soft_reset) begin
      port_cfg <= RST_PORT_CFG;
      ch_index <= RST_CH_INDEX;
      power_reg <= RST_ZERO;
      clk_stab <= RST_ZERO;
      clk_div <= RST_ZERO;
      xfer <= RST_ZERO;
    end else if (wr_strobe) begin
      case (cur_addr)
        ADDR_PORT_CFG: begin
          // either nibble written high sets the pair; fixed bits kept
          port_cfg <= {1'b0, wr_data[6] | wr_data[1],
                       wr_data[5] | wr_data[2], 2'b11,
                       wr_data[5] | wr_data[2],
                       wr_data[6] | wr_data[1], 1'b0};
        end
        ADDR_CH_INDEX: ch_index <= wr_data & CH_INDEX_MASK;
        ADDR_POWER: power_reg <= {6'h00, wr_data[1:0]};
        ADDR_CLK_STAB: clk_stab <= {7'h00, wr_data[0]};
        ADDR_CLK_DIV: clk_div <= {5'h00, wr_data[2:0]};
        ADDR_XFER: xfer <= {7'h00, wr_data[0]};
        default: ;
      endcase
    end else if (xfer[0]) begin
      xfer <= RST_ZERO; // override taken, bit clears
    end
  end

  // local copies written only where the index bit is set
  generate
    for (genvar i = 0; i < NUM_COPIES; i++) begin : g_local
      always_ff @(posedge sys_clk) begin
        if (!resetn || soft_reset) begin
          local_scratch[i] <= RST_ZERO;
        end else if (wr_strobe && cur_addr == ADDR_LOCAL && copy_sel[i]) begin
          local_scratch[i] <= wr_data;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  acr_clock_divider u_div (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .ratio(clk_div[2:0]),
    .clk_en(clk_div_en)
  );

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      power_mode <= ACR_PWR_RUN;
      stabiliser_on <= 1'b0;
      div_enable <= 1'b0;
      override_go <= 1'b0;
      local_sel <= 4'hF;
    end else begin
      power_mode <= acr_power_t'(power_reg[1:0]);
      stabiliser_on <= clk_stab[0];
      div_enable <= clk_div_en;
      override_go <= xfer[0];
      local_sel <= copy_sel;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_soft_reset_clears;
    @(posedge sys_clk) disable iff (!resetn)
    soft_reset |=> (port_cfg == RST_PORT_CFG && ch_index == RST_CH_INDEX);
  endproperty
  a_soft_reset_clears: assert property (p_soft_reset_clears)
    else $error("soft reset did not restore defaults");
  property p_fixed_bits;
    @(posedge sys_clk) disable iff (!resetn)
    port_cfg[0] == 1'b0 && port_cfg[7] == 1'b0 && port_cfg[4:3] == 2'b11;
  endproperty
  a_fixed_bits: assert property (p_fixed_bits)
    else $error("port configuration fixed bits wrong");
  property p_mirror;
    @(posedge sys_clk) disable iff (!resetn)
    port_cfg[6] == port_cfg[1] && port_cfg[5] == port_cfg[2];
  endproperty
  a_mirror: assert property (p_mirror)
    else $error("port configuration nibbles not mirrored");
  property p_stab_follows;
    @(posedge sys_clk) disable iff (!resetn)
    (wr_strobe && cur_addr == ADDR_CLK_STAB && !soft_reset)
      |=> ##1 stabiliser_on == $past(wr_data[0], 2);
  endproperty
  a_stab_follows: assert property (p_stab_follows)
    else $error("stabiliser output did not follow write");
  property p_read_channel_a;
    @(posedge sys_clk) disable iff (!resetn)
    (cur_addr == ADDR_LOCAL && ch_index[CH_A_BIT])
      |-> rd_data == local_scratch[0];
  endproperty
  a_read_channel_a: assert property (p_read_channel_a)
    else $error("multi-select read did not return channel A");
  property p_oe_only_read;
    @(posedge sys_clk) disable iff (!resetn)
    sdio_oe |-> $past(phase) == ACR_RDATA;
  endproperty
  a_oe_only_read: assert property (p_oe_only_read)
    else $error("data pin driven outside a read");
  property p_power_follows;
    @(posedge sys_clk) disable iff (!resetn)
    ##1 power_mode == acr_power_t'($past(power_reg[1:0]));
  endproperty
  a_power_follows: assert property (p_power_follows)
    else $error("power mode output stale");
  property p_index_mask;
    @(posedge sys_clk) disable iff (!resetn)
    (ch_index & ~CH_INDEX_MASK) == 8'h00;
  endproperty
  a_index_mask: assert property (p_index_mask)
    else $error("channel index holds open bits");
endmodule : acr_config_regs

/* core/acr_pkg.sv */
// shared constants for the converter configuration register block
package acr_pkg;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [15:0] ADDR_PORT_CFG = 16'h0000;
  localparam logic [15:0] ADDR_PART_ID = 16'h0001;
  localparam logic [15:0] ADDR_SPEED = 16'h0002;
  localparam logic [15:0] ADDR_CH_INDEX = 16'h0005;
  localparam logic [15:0] ADDR_POWER = 16'h0008;
  localparam logic [15:0] ADDR_CLK_STAB = 16'h0009;
  localparam logic [15:0] ADDR_CLK_DIV = 16'h000B;
  localparam logic [15:0] ADDR_LOCAL = 16'h0010;
  localparam logic [15:0] ADDR_XFER = 16'h00FF;
  // ---------------------------------------------------------------
  // reset values and fields
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_PORT_CFG = 8'h18;
  localparam logic [7:0] RST_CH_INDEX = 8'h33;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] CH_INDEX_MASK = 8'h33;
  localparam int SOFT_RESET_BIT = 5;
  localparam int LSB_FIRST_BIT = 6;
  localparam int CH_A_BIT = 0;
  localparam int CH_B_BIT = 1;
  localparam int NUM_COPIES = 4;
  // identity value is arbitrary, not that of any real part
  localparam logic [7:0] PART_ID_VALUE = 8'h5A;
  // speed grade value is arbitrary
  localparam logic [7:0] SPEED_GRADE_VALUE = 8'h10;
  // ---------------------------------------------------------------
  // serial framing and power modes
  // ---------------------------------------------------------------
  localparam int INSTR_BITS = 16;
  localparam int WORD_BITS = 8;
  typedef enum logic [1:0] {
    ACR_INSTR = 2'b00,
    ACR_WDATA = 2'b01,
    ACR_RDATA = 2'b11
  } acr_phase_t;
  typedef enum logic [1:0] {
    ACR_PWR_RUN = 2'b00,
    ACR_PWR_DOWN = 2'b01,
    ACR_PWR_STBY = 2'b10,
    ACR_PWR_RESET = 2'b11
  } acr_power_t;
endpackage : acr_pkg

/* verif/acr_config_regs_tb_top.sv */
// self-checking bench for the configuration register block
`timescale 1ns/10ps
module acr_config_regs_tb_top;
  import acr_pkg::*;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic port_select_n, serial_clk, sdio_in, sdio_out, sdio_oe;
  acr_power_t power_mode;
  logic stabiliser_on, div_enable, override_go;
  logic [NUM_COPIES-1:0] local_sel;
  int errors = 0;
  int samples_checked = 0;
  logic [7:0] rdata;
  logic oe_ok;
  logic lsb_mode = 1'b0;
  int go_count = 0;
  localparam logic [15:0] RA [8] = '{ADDR_PORT_CFG, ADDR_PART_ID,
    ADDR_SPEED, ADDR_CH_INDEX, ADDR_POWER, ADDR_CLK_STAB, ADDR_CLK_DIV,
    ADDR_XFER};
  localparam logic [7:0] RV [8] = '{RST_PORT_CFG, PART_ID_VALUE,
    SPEED_GRADE_VALUE, RST_CH_INDEX, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] DIVS [3] = '{8'h00, 8'h03, 8'h07};
  always #20 sys_clk = ~sys_clk;
  // the override pulse lasts one cycle, so it is counted as it passes
  always @(negedge sys_clk) begin
    if (override_go === 1'b1) begin
      go_count++;
    end
  end
  acr_config_regs uut (
    .sys_clk(sys_clk), .resetn(resetn), .port_select_n(port_select_n),
    .serial_clk(serial_clk), .sdio_in(sdio_in), .sdio_out(sdio_out),
    .sdio_oe(sdio_oe), .power_mode(power_mode),
    .stabiliser_on(stabiliser_on), .div_enable(div_enable),
    .override_go(override_go), .local_sel(local_sel));
  acr_host_model host (
    .sys_clk(sys_clk), .port_select_n(port_select_n),
    .serial_clk(serial_clk), .sdio_in(sdio_in), .sdio_out(sdio_out),
    .sdio_oe(sdio_oe));
  // ---------------------------------------------------------------
  // access and compare tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR at %0t: seen 0x%0h expected 0x%0h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    host.frame(1'b0, lsb_mode, a, d, rdata, oe_ok);
    check({7'h00, oe_ok}, 8'h01);
  endtask : wr
  task automatic rdchk(input logic [15:0] a, input logic [7:0] e);
    host.frame(1'b1, lsb_mode, a, 8'h00, rdata, oe_ok);
    check({7'h00, oe_ok}, 8'h01);
    check(rdata, e);
  endtask : rdchk
  task automatic div_period(input logic [7:0] exp);
    int n;
    int gap;
    n = 0;
    gap = 1;
    while (div_enable !== 1'b1 && n < 50) begin
      @(negedge sys_clk);
      n++;
    end
    @(negedge sys_clk);
    while (div_enable !== 1'b1 && gap < 50) begin
      @(negedge sys_clk);
      gap++;
    end
    if (n >= 50 || gap >= 50) begin
      errors++;
      conclude();
    end else begin
      check(8'(gap), exp);
    end
  endtask : div_period
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude
  // ---------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (2) @(negedge sys_clk);
    resetn = 1'b1;
    @(negedge sys_clk);
    check({6'h00, power_mode}, 8'h00);
    check({7'h00, stabiliser_on}, 8'h00);
    check({4'h0, local_sel}, 8'h0F);
    check(8'(go_count), 8'h00);
    for (int i = 0; i < 8; i++) rdchk(RA[i], RV[i]);
    $display("test reset values done");
    wr(ADDR_PART_ID, 8'hFF);
    wr(ADDR_SPEED, 8'hFF);
    rdchk(ADDR_PART_ID, PART_ID_VALUE);
    rdchk(ADDR_SPEED, SPEED_GRADE_VALUE);
    rdchk(16'h0013, 8'h00);
    wr(ADDR_PORT_CFG, 8'h81);
    rdchk(ADDR_PORT_CFG, RST_PORT_CFG);
    $display("test fixed and read-only bits done");
    for (int m = 1; m < 5; m++) begin
      wr(ADDR_POWER, 8'(m % 4));
      check({6'h00, power_mode}, 8'(m % 4));
    end
    $display("test power modes done");
    // index set to one channel: global registers must not care
    wr(ADDR_CH_INDEX, 8'h02);
    wr(ADDR_CLK_STAB, 8'h01);
    check({7'h00, stabiliser_on}, 8'h01);
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_CLK_DIV, DIVS[i]);
      div_period(DIVS[i] + 8'h01);
    end
    $display("test clock controls done");
    check({4'h0, local_sel}, 8'h02);
    wr(ADDR_LOCAL, 8'h22);
    wr(ADDR_CH_INDEX, 8'h01);
    check({4'h0, local_sel}, 8'h01);
    wr(ADDR_LOCAL, 8'h11);
    rdchk(ADDR_LOCAL, 8'h11);
    wr(ADDR_CH_INDEX, 8'h02);
    rdchk(ADDR_LOCAL, 8'h22);
    wr(ADDR_CH_INDEX, 8'h30);
    check({4'h0, local_sel}, 8'h0C);
    wr(ADDR_LOCAL, 8'h66);
    wr(ADDR_CH_INDEX, 8'h10);
    rdchk(ADDR_LOCAL, 8'h66);
    wr(ADDR_CH_INDEX, 8'hFF);
    rdchk(ADDR_CH_INDEX, 8'h33);
    rdchk(ADDR_LOCAL, 8'h11);
    // all four copies selected: one write, read back from copies 3 and 1 only
    wr(ADDR_LOCAL, 8'h44);
    wr(ADDR_CH_INDEX, 8'h20);
    rdchk(ADDR_LOCAL, 8'h44);
    wr(ADDR_CH_INDEX, 8'h02);
    rdchk(ADDR_LOCAL, 8'h44);
    $display("test channel index done");
    // lsb-first data words; 0x05 would read back as 0 if not reversed
    wr(ADDR_PORT_CFG, 8'h42);
    lsb_mode = 1'b1;
    wr(ADDR_CLK_DIV, 8'h05);
    rdchk(ADDR_CLK_DIV, 8'h05);
    rdchk(ADDR_PORT_CFG, 8'h5A);
    wr(ADDR_PORT_CFG, 8'h18);
    lsb_mode = 1'b0;
    rdchk(ADDR_PORT_CFG, RST_PORT_CFG);
    wr(ADDR_XFER, 8'h01);
    check(8'(go_count), 8'h01);
    rdchk(ADDR_XFER, 8'h00);
    $display("test bit order and transfer done");
    wr(ADDR_PORT_CFG, 8'h20);
    check({7'h00, stabiliser_on}, 8'h00);
    rdchk(ADDR_CLK_DIV, 8'h00);
    wr(ADDR_CLK_STAB, 8'h01);
    wr(ADDR_CH_INDEX, 8'h01);
    wr(ADDR_LOCAL, 8'h5A);
    wr(ADDR_CLK_DIV, 8'h02);
    wr(ADDR_POWER, 8'h02);
    // low-nibble mirror of the soft reset bit must act the same
    wr(ADDR_PORT_CFG, 8'h04);
    check({7'h00, stabiliser_on}, 8'h00);
    check({6'h00, power_mode}, 8'h00);
    rdchk(ADDR_PORT_CFG, RST_PORT_CFG);
    rdchk(ADDR_CH_INDEX, RST_CH_INDEX);
    rdchk(ADDR_CLK_DIV, 8'h00);
    rdchk(ADDR_LOCAL, 8'h00);
    $display("test soft reset done");
    conclude();
  end
endmodule : acr_config_regs_tb_top

/* verif/acr_host_model.sv */
// serial host model that drives the configuration port
`timescale 1ns/10ps
module acr_host_model (
  input wire logic sys_clk, // system clock
  output logic port_select_n, // frame select, active low
  output logic serial_clk, // serial clock, still outside frames
  output logic sdio_in, // shared data pin as the device sees it
  input wire logic sdio_out, // device read data
  input wire logic sdio_oe // device drive enable
);
  logic host_d;
  logic host_oe;
  logic filler;
  // a released pin toggles so a stale value can never pass as data
  assign sdio_in = sdio_oe ? sdio_out : (host_oe ? host_d : filler);
  initial begin
    port_select_n = 1'b1;
    serial_clk = 1'b0;
    host_d = 1'b0;
    host_oe = 1'b0;
    filler = 1'b0;
  end
  always @(negedge sys_clk) filler <= ~filler;
  // ---------------------------------------------------------------
  // bit and frame tasks
  // ---------------------------------------------------------------
  // four cycles a phase: the port samples the serial clock as data
  task automatic bit_cycle(input logic d, output logic q);
    host_d = d;
    repeat (4) @(negedge sys_clk);
    q = sdio_in;
    serial_clk = 1'b1;
    repeat (4) @(negedge sys_clk);
    serial_clk = 1'b0;
  endtask : bit_cycle
  task automatic frame(input logic rd, input logic lsb,
      input logic [15:0] addr, input logic [7:0] wd,
      output logic [7:0] rdat, output logic oe_ok);
    logic [15:0] ins;
    logic q;
    int j;
    ins = {rd, 2'b00, addr[12:0]};
    oe_ok = 1'b1;
    host_oe = 1'b1;
    port_select_n = 1'b0;
    for (int i = 15; i >= 0; i--) bit_cycle(ins[i], q);
    host_oe = !rd;
    // data words reverse in lsb-first mode; the instruction never does
    for (int i = 7; i >= 0; i--) begin
      j = lsb ? 7 - i : i;
      bit_cycle(wd[j], q);
      rdat[j] = q;
      oe_ok = oe_ok & (sdio_oe === rd);
    end
    repeat (4) @(negedge sys_clk);
    port_select_n = 1'b1;
    host_oe = 1'b0;
    repeat (4) @(negedge sys_clk);
  endtask : frame
endmodule : acr_host_model
